// ===== hdl/bmd_pkg.sv
// Package for the battery monitor and control-bit defaults block
package bmd_pkg;
   // Register word addresses (20-bit register space)
   localparam logic [19:0] ADDR_FLAGS = 20'h7FFF0;
   localparam logic [19:0] ADDR_ALARM_CTL = 20'h7FFF6;
   localparam logic [19:0] ADDR_WDOG = 20'h7FFF7;
   localparam logic [19:0] ADDR_CONTROL = 20'h7FFF8;
   localparam logic [19:0] ADDR_FTEST = 20'h7FFFC;
   localparam logic [19:0] ADDR_IRQ_STAT = 20'h7FFE0;
   localparam logic [19:0] ADDR_IRQ_MASK = 20'h7FFE1;
   // Field positions
   localparam int FLAGS_BATT_LOW_BIT = 4;
   localparam int ALM_FLAG_EN_BIT = 7;
   localparam int ALM_SQUARE_EN_BIT = 6;
   localparam int ALM_BACKUP_EN_BIT = 5;
   localparam int CTL_W_BIT = 7;
   localparam int CTL_R_BIT = 6;
   localparam int FREQ_TEST_BIT = 6;
   localparam int IRQ_CHECK_BIT = 0;
   localparam int IRQ_LOW_BIT = 1;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RST_IRQ = 2'h0;
   // Timing
   localparam int CLK_HZ = 25000000;
   localparam int CHECK_HOURS = 24;
   localparam int SEC_PER_HOUR = 3600;
   localparam int CHECK_SECONDS = CHECK_HOURS * SEC_PER_HOUR;
   localparam int SEC_CYCLES = CLK_HZ;
   localparam int SEC_CNT_W = 25;
   localparam int DAY_CNT_W = 17;
endpackage : bmd_pkg

// ===== hdl/bmd_tick.sv
// One-second enable pulse and daily check pulse from the timebase
`timescale 1ns/1ns
`default_nettype none
module bmd_tick #(
   parameter int SEC_CYCLES = bmd_pkg::SEC_CYCLES,
   parameter int CHECK_SECONDS = bmd_pkg::CHECK_SECONDS
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Control
   input wire logic run,
   // Pulses
   output logic sec_tick,
   output logic day_tick
);
   import bmd_pkg::*;
   logic [SEC_CNT_W-1:0] sec_r;
   logic [DAY_CNT_W-1:0] day_r;
   wire sec_end = (sec_r == SEC_CNT_W'(SEC_CYCLES - 1));
   wire day_end = (day_r == DAY_CNT_W'(CHECK_SECONDS - 1));
   assign sec_tick = run && sec_end;
   assign day_tick = sec_tick && day_end;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sec_r <= '0;
         day_r <= '0;
      end else if (!run) begin
         sec_r <= '0;
         day_r <= '0;
      end else begin
         sec_r <= sec_end ? '0 : sec_r + 1'b1;
         if (sec_tick) begin
            day_r <= day_end ? '0 : day_r + 1'b1;
         end
      end
   end
endmodule : bmd_tick
`default_nettype wire

// ===== hdl/bmd_irq.sv
// Sticky event status with mask and level interrupt
`timescale 1ns/1ns
`default_nettype none
module bmd_irq (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Events and software access
   input wire logic [1:0] events,
   input wire logic clr_we,
   input wire logic [1:0] clr_bits,
   input wire logic mask_we,
   input wire logic [1:0] mask_wdata,
   // State
   output logic [1:0] status,
   output logic [1:0] mask,
   output logic irq
);
   import bmd_pkg::*;
   logic [1:0] status_r;
   logic [1:0] mask_r;
   wire [1:0] clr = clr_we ? clr_bits : 2'h0;
   wire [1:0] status_nxt = (status_r & ~clr) | events;
   assign status = status_r;
   assign mask = mask_r;
   assign irq = |(status_r & mask_r);
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         status_r <= RST_IRQ;
         mask_r <= RST_IRQ;
      end else begin
         status_r <= status_nxt;
         if (mask_we) begin
            mask_r <= mask_wdata;
         end
      end
   end
endmodule : bmd_irq
`default_nettype wire

// ===== hdl/bmd_top.sv
// Battery check sequencing and control-bit defaults on power events
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module bmd_top #(
   parameter int SEC_CYCLES = bmd_pkg::SEC_CYCLES,
   parameter int CHECK_SECONDS = bmd_pkg::CHECK_SECONDS
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Power events
   input wire logic main_power_ok,
   input wire logic first_power_up,
   input wire logic reset_event,
   input wire logic battery_below_threshold,
   // Register port
   input wire logic [19:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Status outputs
   output logic battery_low_flag,
   output logic check_active,
   output logic irq
);
   import bmd_pkg::*;

   typedef enum logic [1:0] {
      ST_BACKUP = 2'b00,
      ST_POWERUP = 2'b01,
      ST_RUN = 2'b11
   } bmd_state_e;

   bmd_state_e state_r;
   bmd_state_e state_nxt;
   logic pwr_d_r;
   logic batt_low_r;
   logic [7:0] flags_low_r;
   logic alarm_flag_en_r;
   logic square_wave_en_r;
   logic alarm_backup_en_r;
   logic [7:0] wdog_r;
   logic ctl_write_r;
   logic ctl_read_r;
   logic [5:0] ctl_cal_r;
   logic freq_test_r;
   logic [7:0] rdata_r;
   logic sec_tick;
   logic day_tick;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;

   // Register address match
   function automatic logic addr_is(input logic [19:0] addr, input logic [19:0] target);
      addr_is = (addr == target);
   endfunction : addr_is

   // Read view of one register, zero when not addressed
   function automatic logic [7:0] gate_view(input logic hit, input logic [7:0] view);
      gate_view = hit ? view : 8'h00;
   endfunction : gate_view

   wire pwr_up = main_power_ok && !pwr_d_r;
   wire pwr_down = !main_power_ok && pwr_d_r;
   wire running = (state_r == ST_RUN);
   wire powerup_check = (state_r == ST_POWERUP);
   wire daily_check = running && day_tick;
   wire do_check = main_power_ok && (powerup_check || daily_check);
   wire check_fail = do_check && battery_below_threshold;
   wire batt_low_nxt = do_check ? battery_below_threshold : batt_low_r;
   wire clear_defaults = first_power_up || reset_event;
   wire clear_on_down = clear_defaults || pwr_down;

   wire hit_flags = addr_is(reg_addr, ADDR_FLAGS);
   wire hit_alarm = addr_is(reg_addr, ADDR_ALARM_CTL);
   wire hit_wdog = addr_is(reg_addr, ADDR_WDOG);
   wire hit_ctl = addr_is(reg_addr, ADDR_CONTROL);
   wire hit_ftest = addr_is(reg_addr, ADDR_FTEST);
   wire hit_istat = addr_is(reg_addr, ADDR_IRQ_STAT);
   wire hit_imask = addr_is(reg_addr, ADDR_IRQ_MASK);
   wire wr_ok = reg_write && main_power_ok;
   wire wr_flags = wr_ok && hit_flags;
   wire wr_alarm = wr_ok && hit_alarm;
   wire wr_wdog = wr_ok && hit_wdog;
   wire wr_ctl = wr_ok && hit_ctl;
   wire wr_ftest = wr_ok && hit_ftest;
   wire wr_istat = wr_ok && hit_istat;
   wire wr_imask = wr_ok && hit_imask;

   wire [7:0] flags_view = {flags_low_r[7:5], batt_low_r, flags_low_r[3:0]};
   wire [7:0] alarm_view = {alarm_flag_en_r, square_wave_en_r, alarm_backup_en_r, 5'h00};
   wire [7:0] ctl_view = {ctl_write_r, ctl_read_r, ctl_cal_r};
   wire [7:0] ftest_view = {1'b0, freq_test_r, 6'h00};
   wire [7:0] istat_view = {6'h00, irq_status};
   wire [7:0] imask_view = {6'h00, irq_mask};
   wire [7:0] rd_mux = gate_view(hit_flags, flags_view) |
                       gate_view(hit_alarm, alarm_view) |
                       gate_view(hit_wdog, wdog_r) |
                       gate_view(hit_ctl, ctl_view) |
                       gate_view(hit_ftest, ftest_view) |
                       gate_view(hit_istat, istat_view) |
                       gate_view(hit_imask, imask_view);

   assign reg_rdata = rdata_r;
   assign battery_low_flag = batt_low_r;
   assign check_active = do_check;

   bmd_tick #(
      .SEC_CYCLES(SEC_CYCLES),
      .CHECK_SECONDS(CHECK_SECONDS)
   ) u_tick (
      .clock(clock),
      .resetn(resetn),
      .run(running),
      .sec_tick(sec_tick),
      .day_tick(day_tick)
   );

   bmd_irq u_irq (
      .clock(clock),
      .resetn(resetn),
      .events({check_fail, do_check}),
      .clr_we(wr_istat),
      .clr_bits(reg_wdata[1:0]),
      .mask_we(wr_imask),
      .mask_wdata(reg_wdata[1:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );

   // Power sequencing
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_BACKUP: begin
            if (pwr_up) begin
               state_nxt = ST_POWERUP;
            end
         end
         ST_POWERUP: begin
            state_nxt = main_power_ok ? ST_RUN : ST_BACKUP;
         end
         ST_RUN: begin
            if (!main_power_ok) begin
               state_nxt = ST_BACKUP;
            end
         end
         default: begin
            state_nxt = ST_BACKUP;
         end
      endcase
   end

   // Power state and supply history for edge detection
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_BACKUP;
         pwr_d_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pwr_d_r <= main_power_ok;
      end
   end

   // Battery-low flag, rewritten only by a check
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         batt_low_r <= 1'b0;
      end else begin
         batt_low_r <= batt_low_nxt;
      end
   end

   // Read data for one cycle after the strobe
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= RST_BYTE;
      end else begin
         rdata_r <= reg_read ? rd_mux : RST_BYTE;
      end
   end

   // Flags register, other bits software-held
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         flags_low_r <= RST_BYTE;
      end else if (wr_flags) begin
         flags_low_r <= reg_wdata;
      end
   end

   // Alarm flag enable
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         alarm_flag_en_r <= 1'b0;
      end else if (clear_defaults) begin
         alarm_flag_en_r <= 1'b0;
      end else if (wr_alarm) begin
         alarm_flag_en_r <= reg_wdata[ALM_FLAG_EN_BIT];
      end
   end

   // Square wave enable
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         square_wave_en_r <= 1'b0;
      end else if (clear_defaults) begin
         square_wave_en_r <= 1'b0;
      end else if (wr_alarm) begin
         square_wave_en_r <= reg_wdata[ALM_SQUARE_EN_BIT];
      end
   end

   // Alarm in backup enable
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         alarm_backup_en_r <= 1'b0;
      end else if (clear_defaults) begin
         alarm_backup_en_r <= 1'b0;
      end else if (wr_alarm) begin
         alarm_backup_en_r <= reg_wdata[ALM_BACKUP_EN_BIT];
      end
   end

   // Watchdog register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wdog_r <= RST_BYTE;
      end else if (clear_on_down) begin
         wdog_r <= RST_BYTE;
      end else if (wr_wdog) begin
         wdog_r <= reg_wdata;
      end
   end

   // Control write bit
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctl_write_r <= 1'b0;
      end else if (clear_on_down) begin
         ctl_write_r <= 1'b0;
      end else if (wr_ctl) begin
         ctl_write_r <= reg_wdata[CTL_W_BIT];
      end
   end

   // Control read bit
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctl_read_r <= 1'b0;
      end else if (clear_on_down) begin
         ctl_read_r <= 1'b0;
      end else if (wr_ctl) begin
         ctl_read_r <= reg_wdata[CTL_R_BIT];
      end
   end

   // Calibration bits, kept across power events
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctl_cal_r <= 6'h00;
      end else if (wr_ctl) begin
         ctl_cal_r <= reg_wdata[5:0];
      end
   end

   // Frequency test bit
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         freq_test_r <= 1'b0;
      end else if (clear_on_down) begin
         freq_test_r <= 1'b0;
      end else if (wr_ftest) begin
         freq_test_r <= reg_wdata[FREQ_TEST_BIT];
      end
   end
endmodule : bmd_top
`default_nettype wire

// ===== tb/bmd_top_properties.sv
// Checker for battery checks and the register read port
`timescale 1ns/1ns
`default_nettype none
module bmd_top_properties
   import bmd_pkg::*;
#(
   parameter int SEC_CYCLES = 4,
   parameter int CHECK_SECONDS = 3
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Inputs
   input wire logic main_power_ok,
   input wire logic first_power_up,
   input wire logic reset_event,
   input wire logic battery_below_threshold,
   input wire logic [19:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   // Outputs
   input wire logic [7:0] reg_rdata,
   input wire logic battery_low_flag,
   input wire logic check_active,
   input wire logic irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   localparam longint DAY_CYCLES = longint'(SEC_CYCLES) * longint'(CHECK_SECONDS);
   longint gap_r;
   // Cycles since the last check while powered
   always_ff @(posedge clock or negedge resetn)
      if (!resetn) gap_r <= 0;
      else gap_r <= (check_active || !main_power_ok) ? 0 : gap_r + 1;
   power_off_quiet_a: assert property (check_active |-> main_power_ok) else $error("check on backup");
   low_sets_flag_a: assert property (check_active && battery_below_threshold |=> battery_low_flag)
      else $error("flag not set");
   pass_clears_a: assert property (check_active && !battery_below_threshold |=> !battery_low_flag)
      else $error("flag not cleared");
   flag_holds_a: assert property (!check_active |=> $stable(battery_low_flag)) else $error("flag moved");
   powerup_check_a: assert property ($rose(main_power_ok) |=> check_active) else $error("no check");
   daily_check_a: assert property (gap_r <= DAY_CYCLES) else $error("check late");
   rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00) else $error("read data not idle");
   flag_read_a: assert property (reg_read && reg_addr == ADDR_FLAGS |=>
      reg_rdata[FLAGS_BATT_LOW_BIT] == $past(battery_low_flag)) else $error("flag read wrong");
   cover property (check_active && battery_below_threshold);
   cover property ($fell(main_power_ok));
   cover property (irq);
endmodule : bmd_top_properties
bind bmd_top bmd_top_properties #(.SEC_CYCLES(SEC_CYCLES), .CHECK_SECONDS(CHECK_SECONDS)) i_props (
   .clock(clock), .resetn(resetn), .main_power_ok(main_power_ok), .first_power_up(first_power_up),
   .reset_event(reset_event), .battery_below_threshold(battery_below_threshold), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .battery_low_flag(battery_low_flag), .check_active(check_active), .irq(irq));
`default_nettype wire

// ===== tb/bmd_supply_model.sv
// Supply and battery comparator model at the far side
`timescale 1ns/1ns
`default_nettype none
module bmd_supply_model (
   // Clock
   input wire logic clock,
   // Bench requests
   input wire logic on_req,
   input wire logic low_req,
   // Supply state
   output logic main_power_ok = 1'b0,
   output logic battery_below_threshold = 1'b0
);
   // Levels move only after an edge
   always @(posedge clock) begin
      main_power_ok <= on_req;
      battery_below_threshold <= low_req;
   end
endmodule : bmd_supply_model
`default_nettype wire

// ===== tb/bmd_top_test.sv
// Testbench for battery checks, defaults and interrupts
`timescale 1ns/1ns
`default_nettype none
module bmd_top_test;
   import bmd_pkg::*;
   logic clock = 0, resetn = 0, fpu = 0, rst_ev = 0, on_req = 0, low_req = 0;
   logic reg_write = 0, reg_read = 0, mpo, bbt, blf, chk, irq;
   logic [19:0] reg_addr = 20'h00000;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   int mismatches = 0, compares = 0, nc;
   always #20 clock = ~clock;
   bmd_supply_model i_sup (.clock(clock), .on_req(on_req), .low_req(low_req), .main_power_ok(mpo),
      .battery_below_threshold(bbt));
   bmd_top #(.SEC_CYCLES(4), .CHECK_SECONDS(3)) i_dut (.clock(clock), .resetn(resetn), .main_power_ok(mpo),
      .first_power_up(fpu), .reset_event(rst_ev), .battery_below_threshold(bbt), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .battery_low_flag(blf), .check_active(chk), .irq(irq));
   task automatic cmp(input string n, input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : cmp
   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      #1;
   endtask : wr
   task automatic rdc(input string n, input logic [19:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 cmp(n, reg_rdata, e);
   endtask : rdc
   task automatic wait_chk;
      nc = 0;
      do begin
         @(posedge clock);
         #1 nc++;
      end while (chk !== 1'b1 && nc < 40);
   endtask : wait_chk
   task automatic set_ctl;
      wr(ADDR_ALARM_CTL, 8'hE0);
      wr(ADDR_WDOG, 8'hFF);
      wr(ADDR_CONTROL, 8'hC5);
      wr(ADDR_FTEST, 8'h40);
   endtask : set_ctl
   task automatic s_defaults;
      for (int ev = 0; ev < 2; ev++) begin
         set_ctl();
         @(posedge clock);
         fpu <= (ev == 0);
         rst_ev <= (ev == 1);
         @(posedge clock);
         fpu <= 1'b0;
         rst_ev <= 1'b0;
         rdc("alarm", ADDR_ALARM_CTL, 8'h00);
         rdc("wdog", ADDR_WDOG, 8'h00);
         rdc("control", ADDR_CONTROL, 8'h05);
         rdc("ftest", ADDR_FTEST, 8'h00);
      end
      rdc("unmapped", 20'h7FF00, 8'h00);
   endtask : s_defaults
   task automatic s_powerdown;
      set_ctl();
      @(posedge clock);
      on_req <= 1'b0;
      low_req <= 1'b1;
      wait_chk();
      cmp("backup check", nc[7:0], 8'd40);
      wr(ADDR_ALARM_CTL, 8'h00);
      @(posedge clock);
      on_req <= 1'b1;
      wait_chk();
      @(posedge clock);
      #1 cmp("low flag", {7'h00, blf}, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h03);
      cmp("irq on", {7'h00, irq}, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h00);
      cmp("irq masked", {7'h00, irq}, 8'h00);
      wr(ADDR_IRQ_STAT, 8'h03);
      rdc("irq status", ADDR_IRQ_STAT, 8'h00);
      wr(ADDR_FLAGS, 8'hEF);
      rdc("flags", ADDR_FLAGS, 8'hFF);
      rdc("alarm kept", ADDR_ALARM_CTL, 8'hE0);
      rdc("wdog", ADDR_WDOG, 8'h00);
      rdc("control", ADDR_CONTROL, 8'h05);
      rdc("ftest", ADDR_FTEST, 8'h00);
   endtask : s_powerdown
   task automatic s_daily;
      @(posedge clock);
      low_req <= 1'b0;
      wait_chk();
      wait_chk();
      cmp("check gap", nc[7:0], 8'd12);
      @(posedge clock);
      #1 cmp("flag cleared", {7'h00, blf}, 8'h00);
   endtask : s_daily
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      on_req <= 1'b1;
      wait_chk();
      s_defaults();
      s_powerdown();
      s_daily();
      tally_and_finish();
   end
   initial begin
      #40000;
      mismatches++;
      tally_and_finish();
   end
endmodule : bmd_top_test
`default_nettype wire
